// ---- hw/epw_pkg.sv ----
`default_nettype none
package epw_pkg;
    // Wishbone word byte addresses.
    localparam logic [3:0] ADDR_CAPTURE_PWM_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_PWM_DELAY_RESTART   = 4'h4;
    localparam logic [3:0] ADDR_PWM_PIN_STEERING    = 4'h8;
    localparam logic [3:0] ADDR_DUTY_HIGH_BYTE      = 4'hC;
    // Reset values.
    localparam logic [7:0] RST_CAPTURE_PWM_CONTROL = 8'h00;
    localparam logic [7:0] RST_PWM_DELAY_RESTART   = 8'h00;
    localparam logic [7:0] RST_PWM_PIN_STEERING    = 8'h01;
    localparam logic [7:0] RST_DUTY_HIGH_BYTE      = 8'h00;
    // Field positions.
    localparam int CFG_MSB      = 7;
    localparam int CFG_LSB      = 6;
    localparam int DUTY_LO_MSB  = 5;
    localparam int DUTY_LO_LSB  = 4;
    localparam int MODE_UP_MSB  = 3;
    localparam int MODE_UP_LSB  = 2;
    localparam int POL_MSB      = 1;
    localparam int POL_LSB      = 0;
    localparam int RSEN_BIT     = 7;
    localparam int SYNC_BIT     = 4;
    localparam logic [7:0] STEER_MASK = 8'h1F;
    localparam logic [1:0] MODE_PWM   = 2'h3;
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_FWD    = 2'h1;
    localparam logic [1:0] CFG_HALF   = 2'h2;
    localparam logic [1:0] CFG_REV    = 2'h3;
    // Instruction cycle is four clocks.
    localparam logic [1:0] ICYC_LAST  = 2'h3;
    localparam logic [9:0] PERIOD_MAX = 10'h3FF;
endpackage : epw_pkg
`default_nettype wire

// ---- hw/epw_edge_delay.sv ----
`default_nettype none
// Delays the rising edge of a level by count instruction cycles; falls at once.
module epw_edge_delay (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       icyc,
    input  wire logic       din,
    input  wire logic [6:0] count,
    output logic            dout
);
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic       next_dout;

    always_comb begin
        next_cnt  = cnt;
        next_dout = dout;
        if (!din) begin
            next_cnt  = 7'h00;
            next_dout = 1'b0;
        end else if (!dout) begin
            // The count is checked every clock so that a count of N gives
            // exactly N instruction cycles, with no extra boundary wait.
            if (cnt >= count) begin
                next_dout = 1'b1;
            end else if (icyc) begin
                next_cnt = cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt  <= 7'h00;
            dout <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            dout <= next_dout;
        end
    end
endmodule : epw_edge_delay
`default_nettype wire

// ---- hw/epw_sync2.sv ----
`default_nettype none
// Two-flop synchroniser.
module epw_sync2 (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      dout
);
    logic meta;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : epw_sync2
`default_nettype wire

// ---- hw/epw_top.sv ----
// The register addresses and the Wishbone slave port are this design's own decisions.
`default_nettype none
module epw_top #(
    parameter bit FULL_BRIDGE = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        shutdown_event,
    output logic             pwm_pin_a,
    output logic             pwm_pin_b,
    output logic             pwm_pin_c,
    output logic             pwm_pin_d,
    output logic      [3:0]  pin_owned,
    output logic      [9:0]  duty_value,
    output logic             shutdown_status_bit
);
    logic [7:0] capture_pwm_control;
    logic [7:0] pwm_delay_restart_control;
    logic [7:0] pwm_pin_steering;
    logic [7:0] duty_high_byte;
    logic [7:0] next_ctl, next_dly, next_str, next_duty;
    logic       next_ack;
    logic [31:0] next_rdata;
    logic       shut_sync;
    logic       next_shut;

    epw_sync2 u_shut_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (shutdown_event),
        .dout   (shut_sync)
    );

    // Register bus, one wait state: ack one cycle after request.
    logic wr_en;
    logic rd_lo;
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd_lo = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    always_comb begin
        next_ctl   = capture_pwm_control;
        next_dly   = pwm_delay_restart_control;
        next_str   = pwm_pin_steering;
        next_duty  = duty_high_byte;
        next_ack   = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_rdata = 32'h0000_0000;
        if (wr_en) begin
            unique case (wb_adr_i)
                epw_pkg::ADDR_CAPTURE_PWM_CONTROL: next_ctl  = wb_dat_i[7:0];
                epw_pkg::ADDR_PWM_DELAY_RESTART:   next_dly  = wb_dat_i[7:0];
                epw_pkg::ADDR_PWM_PIN_STEERING:
                    next_str = wb_dat_i[7:0] & epw_pkg::STEER_MASK;
                epw_pkg::ADDR_DUTY_HIGH_BYTE:      next_duty = wb_dat_i[7:0];
                default: ;
            endcase
        end
        if (rd_lo) begin
            unique case (wb_adr_i)
                epw_pkg::ADDR_CAPTURE_PWM_CONTROL:
                    next_rdata = {24'h00_0000, capture_pwm_control};
                epw_pkg::ADDR_PWM_DELAY_RESTART:
                    next_rdata = {24'h00_0000, pwm_delay_restart_control};
                epw_pkg::ADDR_PWM_PIN_STEERING:
                    next_rdata = {24'h00_0000, pwm_pin_steering};
                epw_pkg::ADDR_DUTY_HIGH_BYTE:
                    next_rdata = {24'h00_0000, duty_high_byte};
                4'h1, 4'h5, 4'h9, 4'hD: next_rdata = {31'h0000_0000, shutdown_status_bit};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Shutdown status: sticky; hardware set wins over software clear.
    logic sw_clr_shut;
    assign sw_clr_shut = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                         && (wb_adr_i == 4'h1) && !wb_dat_i[0];
    always_comb begin
        next_shut = shutdown_status_bit;
        if (shut_sync) begin
            next_shut = 1'b1;
        end else if (pwm_delay_restart_control[epw_pkg::RSEN_BIT]) begin
            next_shut = 1'b0;
        end else if (sw_clr_shut) begin
            next_shut = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            capture_pwm_control       <= epw_pkg::RST_CAPTURE_PWM_CONTROL;
            pwm_delay_restart_control <= epw_pkg::RST_PWM_DELAY_RESTART;
            pwm_pin_steering          <= epw_pkg::RST_PWM_PIN_STEERING;
            duty_high_byte            <= epw_pkg::RST_DUTY_HIGH_BYTE;
            wb_ack_o                  <= 1'b0;
            wb_dat_o                  <= 32'h0000_0000;
            shutdown_status_bit       <= 1'b0;
        end else begin
            capture_pwm_control       <= next_ctl;
            pwm_delay_restart_control <= next_dly;
            pwm_pin_steering          <= next_str;
            duty_high_byte            <= next_duty;
            wb_ack_o                  <= next_ack;
            wb_dat_o                  <= next_rdata;
            shutdown_status_bit       <= next_shut;
        end
    end

    // Field decode.
    logic [1:0] cfg, mode_up, pol;
    logic       is_pwm;
    logic [6:0] dly_count;
    assign cfg       = capture_pwm_control[epw_pkg::CFG_MSB:epw_pkg::CFG_LSB];
    assign mode_up   = capture_pwm_control[epw_pkg::MODE_UP_MSB:epw_pkg::MODE_UP_LSB];
    assign pol       = capture_pwm_control[epw_pkg::POL_MSB:epw_pkg::POL_LSB];
    assign is_pwm    = (mode_up == epw_pkg::MODE_PWM);
    assign dly_count = pwm_delay_restart_control[6:0];

    // Timebase: instruction-cycle strobe and 10-bit period counter.
    logic [1:0] icnt, next_icnt;
    logic [9:0] pcnt, next_pcnt;
    logic       icyc, period_start;
    logic [9:0] next_duty_value;
    assign icyc         = (icnt == epw_pkg::ICYC_LAST);
    assign period_start = icyc && (pcnt == epw_pkg::PERIOD_MAX);
    always_comb begin
        next_icnt       = icnt + 2'h1;
        next_pcnt       = icyc ? pcnt + 10'h001 : pcnt;
        next_duty_value = duty_value;
        if (is_pwm && period_start) begin
            next_duty_value = {duty_high_byte,
                capture_pwm_control[epw_pkg::DUTY_LO_MSB:epw_pkg::DUTY_LO_LSB]};
        end
    end

    // Steering enables latched per sync mode.
    logic [3:0] steer_live, next_steer_live;
    always_comb begin
        next_steer_live = steer_live;
        if (pwm_pin_steering[epw_pkg::SYNC_BIT]) begin
            if (period_start) next_steer_live = pwm_pin_steering[3:0];
        end else if (icyc) begin
            next_steer_live = pwm_pin_steering[3:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            icnt       <= 2'h0;
            pcnt       <= 10'h000;
            duty_value <= 10'h000;
            steer_live <= 4'h1;
        end else begin
            icnt       <= next_icnt;
            pcnt       <= next_pcnt;
            duty_value <= next_duty_value;
            steer_live <= next_steer_live;
        end
    end

    // Raw waveform and delayed edges for both phases.
    logic raw, raw_n, mod_p, mod_n;
    assign raw   = is_pwm && !shutdown_status_bit && (pcnt < duty_value);
    assign raw_n = is_pwm && !shutdown_status_bit && !(pcnt < duty_value);

    epw_edge_delay u_dly_p (
        .clk    (clk),
        .resetn (resetn),
        .icyc   (icyc),
        .din    (raw),
        .count  (dly_count),
        .dout   (mod_p)
    );
    epw_edge_delay u_dly_n (
        .clk    (clk),
        .resetn (resetn),
        .icyc   (icyc),
        .din    (raw_n),
        .count  (dly_count),
        .dout   (mod_n)
    );

    // Output steering; pol bit 1 inverts A/C, bit 0 inverts B/D.
    logic [3:0] act, own, next_pins, next_own;
    always_comb begin
        act = 4'h0;
        own = 4'h0;
        if (!is_pwm) begin
            own = 4'h1;
        end else if (!FULL_BRIDGE) begin
            if (cfg[1]) begin
                act = {2'b00, mod_n, mod_p};
                own = 4'h3;
            end else begin
                act = {3'b000, mod_p};
                own = 4'h1;
            end
        end else begin
            unique case (cfg)
                epw_pkg::CFG_SINGLE: begin
                    act = {4{mod_p}} & steer_live;
                    own = steer_live;
                end
                epw_pkg::CFG_FWD: begin
                    act = {mod_p, 3'b001};
                    own = 4'hF;
                end
                epw_pkg::CFG_HALF: begin
                    act = {2'b00, mod_n, mod_p};
                    own = 4'h3;
                end
                epw_pkg::CFG_REV: begin
                    act = {2'b01, mod_p, 1'b0};
                    own = 4'hF;
                end
            endcase
        end
        next_own  = own;
        next_pins = own & (act ^ {pol[0], pol[1], pol[0], pol[1]});
        if (!is_pwm) begin
            next_pins = 4'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwm_pin_a <= 1'b0;
            pwm_pin_b <= 1'b0;
            pwm_pin_c <= 1'b0;
            pwm_pin_d <= 1'b0;
            pin_owned <= 4'h0;
        end else begin
            pwm_pin_a <= next_pins[0];
            pwm_pin_b <= next_pins[1];
            pwm_pin_c <= next_pins[2];
            pwm_pin_d <= next_pins[3];
            pin_owned <= next_own;
        end
    end

    property p_steer_mask;
        @(posedge clk) disable iff (!resetn) pwm_pin_steering[7:5] == 3'b000;
    endproperty
    a_steer_mask: assert property (p_steer_mask) else $error("steer high bits set");

    property p_cc_owns_a;
        @(posedge clk) disable iff (!resetn) !is_pwm |=> pin_owned == 4'h1;
    endproperty
    a_cc_owns_a: assert property (p_cc_owns_a) else $error("capture pin ownership wrong");

    property p_fwd;
        @(posedge clk) disable iff (!resetn)
            (FULL_BRIDGE && is_pwm && cfg == epw_pkg::CFG_FWD && pol == 2'b00)
            |=> pwm_pin_a && !pwm_pin_b && !pwm_pin_c;
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward bridge levels wrong");

    property p_rev;
        @(posedge clk) disable iff (!resetn)
            (FULL_BRIDGE && is_pwm && cfg == epw_pkg::CFG_REV && pol == 2'b00)
            |=> pwm_pin_c && !pwm_pin_a && !pwm_pin_d;
    endproperty
    a_rev: assert property (p_rev) else $error("reverse bridge levels wrong");

    property p_half_excl;
        @(posedge clk) disable iff (!resetn) !(mod_p && mod_n);
    endproperty
    a_half_excl: assert property (p_half_excl) else $error("both phases active");

    property p_autoclr;
        @(posedge clk) disable iff (!resetn)
            shutdown_status_bit && !shut_sync && pwm_delay_restart_control[epw_pkg::RSEN_BIT]
            |=> !shutdown_status_bit;
    endproperty
    a_autoclr: assert property (p_autoclr) else $error("auto restart missed");

    property p_sticky;
        @(posedge clk) disable iff (!resetn)
            shutdown_status_bit && !pwm_delay_restart_control[epw_pkg::RSEN_BIT] && !sw_clr_shut
            |=> shutdown_status_bit;
    endproperty
    a_sticky: assert property (p_sticky) else $error("shutdown flag lost");

    property p_sync_hold;
        @(posedge clk) disable iff (!resetn)
            pwm_pin_steering[epw_pkg::SYNC_BIT] && !period_start |=> $stable(steer_live);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("steering changed mid period");

    property p_async_apply;
        @(posedge clk) disable iff (!resetn)
            !pwm_pin_steering[epw_pkg::SYNC_BIT] && icyc |=> steer_live == $past(pwm_pin_steering[3:0]);
    endproperty
    a_async_apply: assert property (p_async_apply) else $error("steering not applied");
endmodule : epw_top
`default_nettype wire

// ---- bench/epw_bridge_model.sv ----
`default_nettype none
// Bridge power stage: a fault command raises the shutdown sense line, and the
// stage latches any armed cycle (half_arm with A and B owned) in which both half-bridge switches are on together.
module epw_bridge_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       fault,
    input  wire logic       half_arm,
    input  wire logic       pin_a,
    input  wire logic       pin_b,
    input  wire logic [3:0] pin_owned,
    output logic            shutdown_event,
    output logic            overlap,
    output logic [7:0]      dead_gap
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] gap_run;
    logic       armed;

    assign shutdown_event = fault;
    assign armed          = half_arm && pin_owned[1:0] == 2'b11;

    // The stage also keeps the length of the last stretch with both switches off.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            overlap  <= 1'b0;
            gap_run  <= 8'h00;
            dead_gap <= 8'h00;
        end else if (!armed) begin
            gap_run <= 8'h00;
        end else if (pin_a && pin_b) begin
            overlap <= 1'b1;
        end else if (pin_a || pin_b) begin
            if (gap_run != 8'h00) begin
                dead_gap <= gap_run;
            end
            gap_run <= 8'h00;
        end else begin
            gap_run <= gap_run + 8'h01;
        end
    end
endmodule : epw_bridge_model
`default_nettype wire

// ---- bench/enhanced_pwm_output_steering_tb.sv ----
`default_nettype none
module enhanced_pwm_output_steering_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk      = 1'b0;
    logic        resetn   = 1'b0;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic        fault    = 1'b0;
    logic        half_arm = 1'b0;
    logic [3:0]  adr      = 4'h0;
    logic [3:0]  sel      = 4'h0;
    logic [31:0] wdat     = 32'h0000_0000;
    wire  [31:0] rdat;
    wire  [3:0]  owned;
    wire  [3:0]  owned_h;
    wire  [7:0]  gap;
    wire  [9:0]  duty;
    wire         ack;
    wire         pa;
    wire         pb;
    wire         pc;
    wire         pd;
    wire         sd_evt;
    wire         sts;
    wire         overlap;
    int          mismatches = 0;
    int          checked    = 0;
    int          cyc_cnt    = 0;
    int          seed       = 93354;
    logic [31:0] exp_q[$];

    always #2.5 clk = ~clk;

    epw_top dut_u (
        .clk                 (clk),
        .resetn              (resetn),
        .wb_cyc_i            (cyc),
        .wb_stb_i            (stb),
        .wb_we_i             (we),
        .wb_adr_i            (adr),
        .wb_sel_i            (sel),
        .wb_dat_i            (wdat),
        .wb_dat_o            (rdat),
        .wb_ack_o            (ack),
        .shutdown_event      (sd_evt),
        .pwm_pin_a           (pa),
        .pwm_pin_b           (pb),
        .pwm_pin_c           (pc),
        .pwm_pin_d           (pd),
        .pin_owned           (owned),
        .duty_value          (duty),
        .shutdown_status_bit (sts)
    );

    // A half-bridge unit on the same bus, to cover the reduced configuration set.
    epw_top #(
        .FULL_BRIDGE (1'b0)
    ) dut_half_u (
        .clk                 (clk),
        .resetn              (resetn),
        .wb_cyc_i            (cyc),
        .wb_stb_i            (stb),
        .wb_we_i             (we),
        .wb_adr_i            (adr),
        .wb_sel_i            (sel),
        .wb_dat_i            (wdat),
        .wb_dat_o            (),
        .wb_ack_o            (),
        .shutdown_event      (sd_evt),
        .pwm_pin_a           (),
        .pwm_pin_b           (),
        .pwm_pin_c           (),
        .pwm_pin_d           (),
        .pin_owned           (owned_h),
        .duty_value          (),
        .shutdown_status_bit ()
    );

    epw_bridge_model bridge_u (
        .clk            (clk),
        .resetn         (resetn),
        .fault          (fault),
        .half_arm       (half_arm),
        .pin_a          (pa),
        .pin_b          (pb),
        .pin_owned      (owned),
        .shutdown_event (sd_evt),
        .overlap        (overlap),
        .dead_gap       (gap)
    );

    task results;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles

    // One classic cycle; held until ack is sampled high, then released.
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'h1;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Read results are matched against the oldest expectation.
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", 32'h0000_0001, 32'h0000_0000);
            end else begin
                check("read data", rdat, exp_q.pop_front());
            end
        end
    end

    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            mismatches++;
            results();
        end
    end

    initial begin
        logic [7:0] r;
        logic [1:0] lo;
        cycles(20);
        resetn <= 1'b1;
        rd(4'h0, 32'h0000_0000);
        rd(4'h4, 32'h0000_0000);
        rd(4'h8, 32'h0000_0001);
        rd(4'h2, 32'h0000_0000);
        wb(1'b1, 4'h8, 32'h0000_00FF);
        rd(4'h8, 32'h0000_001F);
        wb(1'b1, 4'h8, 32'h0000_000F);
        cycles(8);
        check("capture owned", {28'h0, owned}, 32'h0000_0001);
        check("capture pins", {28'h0, pd, pc, pb, pa}, 32'h0000_0000);
        wb(1'b1, 4'h8, 32'h0000_0001);
        // Single output with both polarity bits set: a zero duty shows as steered highs.
        wb(1'b1, 4'h0, 32'h0000_000F);
        cycles(8);
        check("single owned", {28'h0, owned}, 32'h0000_0001);
        check("single pins", {28'h0, pd, pc, pb, pa}, 32'h0000_0001);
        check("half unit 0x", {28'h0, owned_h}, 32'h0000_0001);
        wb(1'b1, 4'h8, 32'h0000_000D);
        cycles(8);
        check("steer now", {28'h0, owned}, 32'h0000_000D);
        check("steer now pins", {28'h0, pd, pc, pb, pa}, 32'h0000_000D);
        wb(1'b1, 4'h8, 32'h0000_0013);
        cycles(8);
        check("steer held", {28'h0, owned}, 32'h0000_000D);
        cycles(4200);
        check("steer period", {28'h0, owned}, 32'h0000_0003);
        check("steer period pins", {28'h0, pd, pc, pb, pa}, 32'h0000_0003);
        for (int p = 0; p < 4; p++) begin
            wb(1'b1, 4'h0, 32'h0000_004C | p);
            cycles(8);
            check("fwd owned", {28'h0, owned}, 32'h0000_000F);
            check("fwd a", {31'h0, pa}, {31'h0, ~p[1]});
            check("fwd b", {31'h0, pb}, {31'h0, p[0]});
            check("fwd c", {31'h0, pc}, {31'h0, p[1]});
            check("fwd d", {31'h0, pd}, {31'h0, p[0]});
            check("half unit fwd", {28'h0, owned_h}, 32'h0000_0001);
            wb(1'b1, 4'h0, 32'h0000_00CC | p);
            cycles(8);
            check("rev c", {31'h0, pc}, {31'h0, ~p[1]});
            check("rev a", {31'h0, pa}, {31'h0, p[1]});
            check("rev b", {31'h0, pb}, {31'h0, p[0]});
            check("rev d", {31'h0, pd}, {31'h0, p[0]});
            check("half unit 1x", {28'h0, owned_h}, 32'h0000_0003);
        end
        // Duty kept well clear of both ends so every pulse outlasts the dead band.
        r  = {2'b01, 6'($random(seed))};
        lo = 2'($random(seed));
        wb(1'b1, 4'h8, 32'h0000_0004);
        wb(1'b1, 4'h4, 32'h0000_0005);
        wb(1'b1, 4'hC, {24'h0, r});
        wb(1'b1, 4'h0, {24'h0, 2'b10, lo, 4'hC});
        half_arm <= 1'b1;
        cycles(8);
        check("half owned", {28'h0, owned}, 32'h0000_0003);
        check("half unit half", {28'h0, owned_h}, 32'h0000_0003);
        cycles(8400);
        check("duty", {22'h0, duty}, {22'h0, r, lo});
        check("dead band", {31'h0, overlap}, 32'h0000_0000);
        // Five instruction cycles of four clocks each.
        check("dead time", {24'h0, gap}, 32'h0000_0014);
        half_arm <= 1'b0;
        wb(1'b1, 4'h4, 32'h0000_0000);
        fault <= 1'b1;
        cycles(8);
        check("shutdown set", {31'h0, sts}, 32'h0000_0001);
        fault <= 1'b0;
        cycles(8);
        check("shutdown kept", {31'h0, sts}, 32'h0000_0001);
        rd(4'h1, 32'h0000_0001);
        wb(1'b1, 4'h1, 32'h0000_0000);
        rd(4'h1, 32'h0000_0000);
        wb(1'b1, 4'h4, 32'h0000_0085);
        fault <= 1'b1;
        cycles(8);
        check("auto set", {31'h0, sts}, 32'h0000_0001);
        fault <= 1'b0;
        cycles(8);
        check("auto clear", {31'h0, sts}, 32'h0000_0000);
        cycles(4);
        results();
    end
endmodule : enhanced_pwm_output_steering_tb
`default_nettype wire
